/* mad_pkg.sv */
// Constants, variants and carrier types for the memory address decoder.
// Assumes one clock domain; every file imports this package.
package mad_pkg;

  // ----------------------------------------------------------------
  // Register file map
  // ----------------------------------------------------------------
  localparam int RF_SIZE = 4096;
  localparam logic [3:0] RF_CTRL_PAGE = 4'hf;
  localparam logic [11:0] RF_CTRL_BASE = 12'hf00;
  localparam logic [11:0] RF_CTRL_END = 12'hfff;
  localparam logic [11:0] RF_RAM_BASE = 12'h000;
  localparam logic [11:0] RF_RAM_1K_END = 12'h3ff;
  localparam logic [11:0] RF_RAM_2K_END = 12'h7ff;
  localparam logic [1:0] RF_RELOC_1K_BLOCK = 2'h1;
  localparam logic [1:0] RF_RELOC_2K_BLOCK = 2'h2;
  localparam int RRAM_DEPTH = 2048;
  localparam int PROGRAM_RAM_REGION_DEPTH = 1024;
  localparam logic [7:0] RF_HOLE_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Program memory map
  // ----------------------------------------------------------------
  localparam logic [15:0] PM_OPT_END = 16'h0001;
  localparam logic [15:0] PM_RESET_VEC_END = 16'h0003;
  localparam logic [15:0] PM_WDOG_VEC_END = 16'h0005;
  localparam logic [15:0] PM_ILL_TRAP_END = 16'h0007;
  localparam logic [15:0] PM_IRQ_VEC_END = 16'h0037;
  localparam logic [15:0] PM_OSC_TRAP_END = 16'h003d;
  localparam logic [15:0] PM_FLASH_END_24K = 16'h5fff;
  localparam logic [15:0] PM_FLASH_END_16K = 16'h3fff;
  localparam logic [15:0] PM_FLASH_END_8K = 16'h1fff;
  localparam logic [15:0] PM_PROGRAM_RAM_REGION_BASE = 16'he000;
  localparam logic [15:0] PM_PROGRAM_RAM_REGION_END = 16'he3ff;
  localparam logic [15:0] PM_INFO_BASE = 16'hfe00;
  localparam logic [7:0] PM_UNIMPL_DATA = 8'hff;
  localparam logic [7:0] DM_EMPTY_DATA = 8'hff;

  // ----------------------------------------------------------------
  // Information area
  // ----------------------------------------------------------------
  localparam int FPS_INFO_BIT = 7;
  localparam logic [8:0] INFO_PART_BASE = 9'h040;
  localparam logic [8:0] INFO_PART_END = 9'h053;
  localparam int INFO_PART_LEN = 20;
  localparam logic [8:0] INFO_CAL0 = 9'h060;
  localparam logic [8:0] INFO_CAL1 = 9'h061;
  localparam logic [8:0] INFO_OPT_END = 9'h03f;
  // Arbitrary part identifier, padded with all-ones bytes
  localparam logic [8*INFO_PART_LEN-1:0] INFO_PART_ID = {"MADEC01", {13{8'hff}}};
  // Arbitrary factory values
  localparam logic [7:0] INFO_OPT_VALUE = 8'hff;
  localparam logic [7:0] INFO_CAL0_VALUE = 8'h80;
  localparam logic [7:0] INFO_CAL1_VALUE = 8'h00;
  localparam logic [7:0] INFO_FILL = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MAD_VAR_24K = 2'b00,
    MAD_VAR_16K = 2'b01,
    MAD_VAR_8K = 2'b11
  } mad_variant_t;

  typedef enum logic [3:0] {
    MAD_AREA_OPT = 4'h0,
    MAD_AREA_RESET_VEC = 4'h1,
    MAD_AREA_WATCHDOG_VECTOR = 4'h2,
    MAD_AREA_ILL_TRAP = 4'h3,
    MAD_AREA_IRQ_VEC = 4'h4,
    MAD_AREA_OSC_TRAP = 4'h5,
    MAD_AREA_CODE = 4'h6,
    MAD_AREA_PROGRAM_RAM_REGION = 4'h7,
    MAD_AREA_INFO = 4'h8,
    MAD_AREA_NONE = 4'h9
  } mad_pm_area_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mad_rf_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mad_pm_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mad_resp_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mad_ctrl_wr_t;

endpackage

/* mad_info_rom.sv */
// Read-only information area contents, looked up by byte offset.
// Assumes the caller only presents offsets inside the 512-byte area.
`timescale 1ns/1ps
module mad_info_rom (
  input wire logic [8:0] offset_in,
  output logic [7:0] data_out
);
  import mad_pkg::*;

  logic [8:0] part_off;
  logic [4:0] part_idx;
  logic in_opt;
  logic in_part;
  logic [7:0] part_byte;

  assign in_opt = offset_in <= INFO_OPT_END;
  assign in_part = offset_in >= INFO_PART_BASE && offset_in <= INFO_PART_END;
  assign part_off = offset_in - INFO_PART_BASE;
  assign part_idx = part_off[4:0];
  // First character sits in the lowest address
  assign part_byte = INFO_PART_ID[8*(INFO_PART_LEN-1-int'(part_idx)) +: 8];

  assign data_out = in_opt ? INFO_OPT_VALUE :
                    in_part ? part_byte : // see [R16]
                    (offset_in == INFO_CAL0) ? INFO_CAL0_VALUE :
                    (offset_in == INFO_CAL1) ? INFO_CAL1_VALUE : INFO_FILL;
endmodule // mad_info_rom

/* mad_decoder.sv */
// Address decoder for the register file, program and data memory spaces.
// Assumes peripherals answer control-page reads in the request cycle and
// that flash read data follows the program address combinationally.
//
// Behaviour
// [R1] Register file holds 4096 byte addresses
// [R2] F00h-FFFh go to control registers
// [R3] Unassigned control reads give undefined data
// [R4] Software avoids writing unassigned control addresses
// [R5] Register RAM from 000h, 1KB or 2KB
// [R6] Holes above RAM: undefined reads, ignored writes
// [R7] Relocated program RAM joins register RAM
// [R8] 64KB program space, 8KB-24KB flash
// [R9] Unimplemented program reads FFh, writes ignored
// [R10] Option bits, vectors and traps classified
// [R11] Program RAM at E000-E3FF above flash
// [R12] Data memory space is empty
// [R13] Page select bit 7 enables information area
// [R14] Enabled overlay returns information bytes FE00-FFFF
// [R15] Information area cannot be written
// [R16] Part identifier and factory bytes held
// [R17] Software uses only first two calibration bytes
// [R18] Source operands read, destinations written
// [R19] Unimplemented peripheral addresses are reserved
// [R20] Overlay off: FE00-FFFF decode normally
`timescale 1ns/1ps
module mad_decoder (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire mad_pkg::mad_variant_t variant_in,
  input wire logic program_ram_relocate_option_in,
  input wire logic [7:0] flash_page_select_in,
  input wire mad_pkg::mad_rf_req_t rf_req_in,
  input wire logic ctrl_hit_in,
  input wire logic [7:0] ctrl_rdata_in,
  input wire mad_pkg::mad_pm_req_t pm_req_in,
  input wire logic [7:0] flash_rdata_in,
  input wire logic dm_rd_in,
  output mad_pkg::mad_resp_t rf_resp_out,
  output mad_pkg::mad_ctrl_wr_t ctrl_wr_out,
  output mad_pkg::mad_resp_t pm_resp_out,
  output mad_pkg::mad_pm_area_t pm_area_out,
  output logic flash_sel_out,
  output mad_pkg::mad_resp_t dm_resp_out
);
  import mad_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] rram [RRAM_DEPTH];
  logic [7:0] program_ram_region [PROGRAM_RAM_REGION_DEPTH];

  // ----------------------------------------------------------------
  // Register file decode
  // ----------------------------------------------------------------
  logic small_ram;
  logic [11:0] rram_end;
  logic [1:0] reloc_block;
  logic rf_ctrl;
  logic rf_rram;
  logic rf_rpram;
  logic [7:0] rf_ctrl_data;
  logic [7:0] next_rf_data;

  assign small_ram = variant_in == MAD_VAR_8K;
  assign rram_end = small_ram ? RF_RAM_1K_END : RF_RAM_2K_END; // see [R5]
  assign reloc_block = small_ram ? RF_RELOC_1K_BLOCK : RF_RELOC_2K_BLOCK;
  assign rf_ctrl = rf_req_in.addr[11:8] == RF_CTRL_PAGE; // see [R1] see [R2]
  assign rf_rram = !rf_ctrl && rf_req_in.addr <= rram_end; // see [R5]
  assign rf_rpram = program_ram_relocate_option_in &&
                    rf_req_in.addr[11:10] == reloc_block; // see [R7]
  // Reserved control addresses give a fixed filler
  assign rf_ctrl_data = ctrl_hit_in ? ctrl_rdata_in : RF_HOLE_DATA; // see [R3] see [R19]
  assign next_rf_data = rf_ctrl ? rf_ctrl_data :
                        rf_rram ? rram[rf_req_in.addr[10:0]] :
                        rf_rpram ? program_ram_region[rf_req_in.addr[9:0]] :
                        RF_HOLE_DATA; // see [R6]

  // ----------------------------------------------------------------
  // Program memory decode
  // ----------------------------------------------------------------
  logic [15:0] flash_end;
  logic info_en;
  logic pm_info;
  logic pm_flash;
  logic pm_program_ram_region;
  logic [7:0] info_data;
  logic [7:0] next_pm_data;
  mad_pm_area_t next_area;

  assign flash_end = (variant_in == MAD_VAR_24K) ? PM_FLASH_END_24K :
                     (variant_in == MAD_VAR_16K) ? PM_FLASH_END_16K :
                     PM_FLASH_END_8K; // see [R8]
  assign info_en = flash_page_select_in[FPS_INFO_BIT]; // see [R13]
  assign pm_info = info_en && pm_req_in.addr >= PM_INFO_BASE; // see [R14] see [R20]
  assign pm_flash = !pm_info && pm_req_in.addr <= flash_end;
  assign pm_program_ram_region = !pm_info && !program_ram_relocate_option_in &&
                   pm_req_in.addr >= PM_PROGRAM_RAM_REGION_BASE &&
                   pm_req_in.addr <= PM_PROGRAM_RAM_REGION_END; // see [R11]
  assign next_pm_data = pm_info ? info_data :
                        pm_flash ? flash_rdata_in :
                        pm_program_ram_region ? program_ram_region[pm_req_in.addr[9:0]] :
                        PM_UNIMPL_DATA; // see [R9]
  assign next_area = pm_info ? MAD_AREA_INFO :
                     pm_program_ram_region ? MAD_AREA_PROGRAM_RAM_REGION :
                     !pm_flash ? MAD_AREA_NONE :
                     pm_req_in.addr <= PM_OPT_END ? MAD_AREA_OPT :
                     pm_req_in.addr <= PM_RESET_VEC_END ? MAD_AREA_RESET_VEC :
                     pm_req_in.addr <= PM_WDOG_VEC_END ? MAD_AREA_WATCHDOG_VECTOR :
                     pm_req_in.addr <= PM_ILL_TRAP_END ? MAD_AREA_ILL_TRAP :
                     pm_req_in.addr <= PM_IRQ_VEC_END ? MAD_AREA_IRQ_VEC :
                     pm_req_in.addr <= PM_OSC_TRAP_END ? MAD_AREA_OSC_TRAP :
                     MAD_AREA_CODE; // see [R10]

  mad_info_rom u_info_rom (
    .offset_in(pm_req_in.addr[8:0]),
    .data_out(info_data)
  );

  // ----------------------------------------------------------------
  // Write enables
  // ----------------------------------------------------------------
  logic rram_we;
  logic program_ram_region_rf_we;
  logic program_ram_region_pm_we;
  logic ctrl_we;

  assign rram_we = ce_in && rf_req_in.wr && rf_rram; // see [R18] see [R6]
  assign program_ram_region_rf_we = ce_in && rf_req_in.wr && !rf_rram && !rf_ctrl && rf_rpram;
  // Overlay and unimplemented space never reach storage
  assign program_ram_region_pm_we = ce_in && pm_req_in.wr && pm_program_ram_region; // see [R15] see [R9]
  assign ctrl_we = ce_in && rf_req_in.wr && rf_ctrl; // see [R4]

  always_ff @(posedge ref_clk_in) begin
    if (rram_we) begin
      rram[rf_req_in.addr[10:0]] <= rf_req_in.wdata;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (program_ram_region_rf_we) begin
      program_ram_region[rf_req_in.addr[9:0]] <= rf_req_in.wdata;
    end else if (program_ram_region_pm_we) begin
      program_ram_region[pm_req_in.addr[9:0]] <= pm_req_in.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Registered answers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rf_resp_out <= '0;
      ctrl_wr_out <= '0;
      pm_resp_out <= '0;
      pm_area_out <= MAD_AREA_NONE;
      flash_sel_out <= 1'b0;
      dm_resp_out <= '0;
    end else if (ce_in) begin
      rf_resp_out <= '{valid: rf_req_in.rd, data: next_rf_data}; // see [R18]
      ctrl_wr_out <= '{wr: ctrl_we, addr: rf_req_in.addr[7:0], wdata: rf_req_in.wdata};
      pm_resp_out <= '{valid: pm_req_in.rd, data: next_pm_data};
      pm_area_out <= next_area;
      flash_sel_out <= pm_req_in.rd && pm_flash;
      dm_resp_out <= '{valid: dm_rd_in, data: DM_EMPTY_DATA}; // see [R12]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  unimpl_reads_ff_a: assert property ( // see [R9]
    ce_in && pm_req_in.rd && !pm_info && !pm_flash && !pm_program_ram_region
    |=> pm_resp_out.valid && pm_resp_out.data == 8'hff)
    else $error("unimplemented program read not ff");

  overlay_data_a: assert property ( // see [R14]
    ce_in && pm_req_in.rd && info_en && pm_req_in.addr >= 16'hfe00
    |=> pm_resp_out.data == $past(info_data) && pm_area_out == MAD_AREA_INFO)
    else $error("overlay did not return information byte");

  overlay_off_a: assert property ( // see [R20]
    ce_in && pm_req_in.rd && !info_en && pm_req_in.addr >= 16'hfe00
    |=> pm_resp_out.data == 8'hff && pm_area_out == MAD_AREA_NONE)
    else $error("top of program space decoded wrongly with overlay off");

  ctrl_page_a: assert property ( // see [R2]
    ce_in && rf_req_in.wr && rf_req_in.addr >= 12'hf00
    |=> ctrl_wr_out.wr && ctrl_wr_out.addr == $past(rf_req_in.addr[7:0]))
    else $error("control page write not forwarded");

  ctrl_only_a: assert property ( // see [R2]
    ctrl_wr_out.wr |-> $past(rf_req_in.addr[11:8]) == 4'hf)
    else $error("control write outside control page");

  rram_roundtrip_a: assert property ( // see [R18]
    ce_in && rf_req_in.wr && rf_rram && !rf_req_in.rd
    ##1 ce_in && rf_req_in.rd && !rf_req_in.wr &&
        rf_req_in.addr == $past(rf_req_in.addr)
    |=> rf_resp_out.data == $past(rf_req_in.wdata, 2))
    else $error("register RAM lost written byte");

  small_ram_hole_a: assert property ( // see [R5] see [R6]
    ce_in && rf_req_in.rd && small_ram && !program_ram_relocate_option_in &&
    rf_req_in.addr[11:10] == 2'h1
    |=> rf_resp_out.data == 8'h00)
    else $error("1KB variant answered above its RAM");

  program_ram_region_not_in_pm_a: assert property ( // see [R7] see [R11]
    ce_in && pm_req_in.rd && program_ram_relocate_option_in &&
    pm_req_in.addr >= 16'he000 && pm_req_in.addr <= 16'he3ff
    |=> pm_resp_out.data == 8'hff)
    else $error("relocated program RAM still seen in program space");

  vector_area_a: assert property ( // see [R10]
    ce_in && pm_req_in.addr inside {16'h0004, 16'h0005} && !pm_info
    |=> pm_area_out == MAD_AREA_WATCHDOG_VECTOR)
    else $error("watchdog vector misclassified");

  data_space_empty_a: assert property ( // see [R12]
    ce_in && dm_rd_in |=> dm_resp_out.valid && dm_resp_out.data == 8'hff)
    else $error("data memory space answered with data");

  freeze_a: assert property (
    !ce_in |=> $stable(rf_resp_out) && $stable(pm_resp_out))
    else $error("outputs moved while clock enable low");

  // ----------------------------------------------------------------
  // Decode checks
  // ----------------------------------------------------------------
  // Register file side
  rf_valid_a: assert property ( // see [R18]
    ce_in && rf_req_in.rd
    |=> rf_resp_out.valid)
    else $error("register read not answered");

  rf_quiet_a: assert property ( // see [R18]
    ce_in && !rf_req_in.rd
    |=> !rf_resp_out.valid)
    else $error("register answer without read");

  hole_write_a: assert property ( // see [R6]
    ce_in && rf_req_in.wr && !rf_ctrl && !rf_rram && !rf_rpram
    |-> !rram_we && !program_ram_region_rf_we)
    else $error("write to register hole reached storage");

  ctrl_read_a: assert property ( // see [R2]
    ce_in && rf_req_in.rd && rf_ctrl && ctrl_hit_in
    |=> rf_resp_out.data == $past(ctrl_rdata_in))
    else $error("control register read data lost");

  reloc_write_a: assert property ( // see [R7]
    ce_in && rf_req_in.wr && program_ram_relocate_option_in && !rf_ctrl && !rf_rram &&
    rf_req_in.addr[11:10] == reloc_block
    |-> program_ram_region_rf_we)
    else $error("relocated program RAM not written");

  // Program memory side
  flash_sel_a: assert property ( // see [R8]
    ce_in && pm_req_in.rd && !pm_info && pm_req_in.addr <= flash_end
    |=> flash_sel_out)
    else $error("flash read not selected");

  code_area_a: assert property ( // see [R11]
    ce_in && !pm_info && pm_req_in.addr >= 16'h003e && pm_req_in.addr <= flash_end
    |=> pm_area_out == MAD_AREA_CODE)
    else $error("flash code address misclassified");

  program_ram_region_area_a: assert property ( // see [R11]
    ce_in && !info_en && !program_ram_relocate_option_in &&
    pm_req_in.addr >= 16'he000 && pm_req_in.addr <= 16'he3ff
    |=> pm_area_out == MAD_AREA_PROGRAM_RAM_REGION)
    else $error("program RAM address misclassified");

  info_no_write_a: assert property ( // see [R15]
    ce_in && pm_req_in.wr && info_en && pm_req_in.addr >= 16'hfe00
    |-> !program_ram_region_pm_we)
    else $error("overlay write reached storage");

  part_first_a: assert property ( // see [R16]
    ce_in && pm_req_in.rd && info_en && pm_req_in.addr == 16'hfe40
    |=> pm_resp_out.data == INFO_PART_ID[8*INFO_PART_LEN-1 -: 8])
    else $error("part identifier does not start at first byte");

  reset_vec_a: assert property ( // see [R10]
    ce_in && !pm_info && pm_req_in.addr inside {16'h0002, 16'h0003}
    |=> pm_area_out == MAD_AREA_RESET_VEC)
    else $error("reset vector misclassified");

  irq_area_a: assert property ( // see [R10]
    ce_in && pm_req_in.addr >= 16'h0008 && pm_req_in.addr <= 16'h0037
    |=> pm_area_out == MAD_AREA_IRQ_VEC)
    else $error("interrupt vector misclassified");

  pm_quiet_a: assert property ( // see [R9]
    ce_in && !pm_req_in.rd
    |=> !pm_resp_out.valid && !flash_sel_out)
    else $error("program answer without read");

  hole_write_c: cover property (ce_in && rf_req_in.wr && !rf_ctrl && !rf_rram && !rf_rpram);
  overlay_cover_c: cover property (ce_in && pm_req_in.rd && pm_info);
  reloc_cover_c: cover property (ce_in && rf_req_in.wr && program_ram_region_rf_we);
  program_ram_region_pm_cover_c: cover property (ce_in && pm_req_in.wr && pm_program_ram_region);
  reserved_ctrl_c: cover property (ce_in && rf_req_in.rd && rf_ctrl && !ctrl_hit_in);
endmodule // mad_decoder

/* mad_cpu_model.sv */
// CPU-side request model for the decoder's three request ports.
// Assumes every task call starts at a falling clock edge.
`timescale 1ns/1ps
module mad_cpu_model (
  input wire logic ref_clk_in,
  output mad_pkg::mad_rf_req_t rf_req_out,
  output mad_pkg::mad_pm_req_t pm_req_out,
  output logic dm_rd_out
);
  import mad_pkg::*;

  initial begin
    rf_req_out = '0;
    pm_req_out = '0;
    dm_rd_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // One request held over one rising edge
  // ----------------------------------------------------------------
  // Bus 0 register file, 1 program, 2 data, 3 none; idle buses invert
  task automatic go(input logic [1:0] bus, input logic rd, input logic wr,
                    input logic [15:0] addr, input logic [7:0] wdata);
    if (bus == 2'd0) begin
      rf_req_out = {rd, wr, addr[11:0], wdata};
    end else begin
      rf_req_out = {2'b00, ~rf_req_out.addr, ~rf_req_out.wdata};
    end
    if (bus == 2'd1) begin
      pm_req_out = {rd, wr, addr, wdata};
    end else begin
      pm_req_out = {2'b00, ~pm_req_out.addr, ~pm_req_out.wdata};
    end
    dm_rd_out = (bus == 2'd2);
    @(negedge ref_clk_in);
  endtask
endmodule // mad_cpu_model

/* memory_address_decoder_tb.sv */
// Self-checking bench for mad_decoder, driven through mad_cpu_model.
// Assumes mad_pkg and the model are compiled first.
`timescale 1ns/1ps
`define chk(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module memory_address_decoder_tb;
  import mad_pkg::*;

  logic ref_clk_in, rst_in, ce_in, reloc, dm_rd, ctrl_hit, flash_sel;
  mad_variant_t variant;
  logic [7:0] fps, flash_rdata, ctrl_rdata;
  mad_rf_req_t rf_req;
  mad_pm_req_t pm_req;
  mad_resp_t rf_resp, pm_resp, dm_resp;
  mad_ctrl_wr_t ctrl_wr;
  mad_pm_area_t pm_area;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 82;
  logic [7:0] rsh [logic [11:0]];
  logic [7:0] psh [logic [15:0]];

  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  function automatic logic hit_fn(logic [11:0] a);
    return a >= RF_CTRL_BASE && a[7:0] <= 8'h2e;
  endfunction
  function automatic logic [7:0] flash_fn(logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h3c;
  endfunction
  assign ctrl_hit = hit_fn(rf_req.addr);
  assign ctrl_rdata = rf_req.addr[7:0] ^ 8'ha5;
  assign flash_rdata = flash_fn(pm_req.addr);
  function automatic logic [11:0] ram_top();
    return (variant == MAD_VAR_8K) ? RF_RAM_1K_END : RF_RAM_2K_END;
  endfunction
  // Relocated block starts right after register RAM
  function automatic logic rf_mem(logic [11:0] a);
    return a <= ram_top() || (reloc && a > ram_top() && a <= ram_top() + 12'h400);
  endfunction
  function automatic logic [7:0] rf_exp(logic [11:0] a);
    if (a >= RF_CTRL_BASE) return hit_fn(a) ? (a[7:0] ^ 8'ha5) : RF_HOLE_DATA;
    return rf_mem(a) ? rsh[a] : RF_HOLE_DATA;
  endfunction
  function automatic mad_pm_area_t area_fn(logic [15:0] a);
    logic [15:0] fe;
    fe = (variant == MAD_VAR_24K) ? PM_FLASH_END_24K :
         (variant == MAD_VAR_16K) ? PM_FLASH_END_16K : PM_FLASH_END_8K;
    if (fps[FPS_INFO_BIT] && a >= PM_INFO_BASE) return MAD_AREA_INFO;
    if (a <= PM_OPT_END) return MAD_AREA_OPT;
    if (a <= PM_RESET_VEC_END) return MAD_AREA_RESET_VEC;
    if (a <= PM_WDOG_VEC_END) return MAD_AREA_WATCHDOG_VECTOR;
    if (a <= PM_ILL_TRAP_END) return MAD_AREA_ILL_TRAP;
    if (a <= PM_IRQ_VEC_END) return MAD_AREA_IRQ_VEC;
    if (a <= PM_OSC_TRAP_END) return MAD_AREA_OSC_TRAP;
    if (a <= fe) return MAD_AREA_CODE;
    if (!reloc && a >= PM_PROGRAM_RAM_REGION_BASE && a <= PM_PROGRAM_RAM_REGION_END) return MAD_AREA_PROGRAM_RAM_REGION;
    return MAD_AREA_NONE;
  endfunction
  function automatic logic [7:0] info_fn(logic [8:0] o);
    if (o <= INFO_OPT_END) return INFO_OPT_VALUE;
    if (o >= INFO_PART_BASE && o <= INFO_PART_END)
      return INFO_PART_ID[8*(INFO_PART_LEN-1-int'(o-INFO_PART_BASE)) +: 8];
    if (o == INFO_CAL0) return INFO_CAL0_VALUE;
    if (o == INFO_CAL1) return INFO_CAL1_VALUE;
    return INFO_FILL;
  endfunction
  function automatic logic [7:0] pm_exp(logic [15:0] a);
    case (area_fn(a))
      MAD_AREA_INFO: return info_fn(a[8:0]);
      MAD_AREA_PROGRAM_RAM_REGION: return psh[a];
      MAD_AREA_NONE: return PM_UNIMPL_DATA;
      default: return flash_fn(a);
    endcase
  endfunction

  mad_decoder uut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in), .variant_in(variant),
    .program_ram_relocate_option_in(reloc), .flash_page_select_in(fps), .rf_req_in(rf_req),
    .ctrl_hit_in(ctrl_hit), .ctrl_rdata_in(ctrl_rdata), .pm_req_in(pm_req),
    .flash_rdata_in(flash_rdata), .dm_rd_in(dm_rd), .rf_resp_out(rf_resp),
    .ctrl_wr_out(ctrl_wr), .pm_resp_out(pm_resp), .pm_area_out(pm_area),
    .flash_sel_out(flash_sel), .dm_resp_out(dm_resp)
  );
  mad_cpu_model cpu (
    .ref_clk_in(ref_clk_in), .rf_req_out(rf_req), .pm_req_out(pm_req), .dm_rd_out(dm_rd)
  );

  // ----------------------------------------------------------------
  // Accesses and scenarios
  // ----------------------------------------------------------------
  task automatic rf_acc(input logic rd, input logic wr, input logic [11:0] a,
                        input logic [7:0] d);
    cpu.go(2'd0, rd, wr, {4'h0, a}, d);
    if (wr && rf_mem(a)) rsh[a] = d;
    `chk("ctrl_wr", wr && a >= RF_CTRL_BASE, ctrl_wr.wr)
    if (wr && a >= RF_CTRL_BASE) `chk("ctrl_wr_ad", {a[7:0], d}, {ctrl_wr.addr, ctrl_wr.wdata})
    `chk("rf_valid", rd, rf_resp.valid)
    if (rd) `chk("rf_data", rf_exp(a), rf_resp.data)
  endtask
  task automatic run_rf();
    logic [11:0] cn [11];
    logic [11:0] a;
    cn = '{12'h000, ram_top(), ram_top() + 12'h1, ram_top() + 12'h400, ram_top() + 12'h401,
           12'hbff, 12'hc00, 12'heff, 12'hf00, 12'hf2e, 12'hf2f};
    for (int i = 0; i < 41; i++) begin
      a = (i < 11) ? cn[i] : 12'($random(seed));
      if (a < RF_CTRL_BASE || hit_fn(a)) rf_acc(1'b0, 1'b1, a, 8'($random(seed)));
      rf_acc(1'b1, 1'b0, a, 8'h00);
    end
    rf_acc(1'b0, 1'b1, 12'h010, 8'h5a);
    ce_in = 1'b0;
    cpu.go(2'd0, 1'b0, 1'b1, 16'h0010, 8'ha5);
    ce_in = 1'b1;
    rf_acc(1'b1, 1'b0, 12'h010, 8'h00);
  endtask
  task automatic pm_acc(input logic [15:0] a);
    logic [7:0] d;
    d = 8'($random(seed));
    cpu.go(2'd1, 1'b0, 1'b1, a, d);
    if (area_fn(a) == MAD_AREA_PROGRAM_RAM_REGION) psh[a] = d;
    `chk("pm_wr_valid", 1'b0, pm_resp.valid)
    cpu.go(2'd1, 1'b1, 1'b0, a, 8'h00);
    `chk("pm_area", area_fn(a), pm_area)
    `chk("pm_valid", 1'b1, pm_resp.valid)
    `chk("pm_data", pm_exp(a), pm_resp.data)
    if (area_fn(a) != MAD_AREA_INFO) `chk("flash_sel", area_fn(a) <= MAD_AREA_CODE, flash_sel)
  endtask
  task automatic run_pm();
    logic [15:0] pc [18];
    logic [15:0] it [7];
    pc = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h0037, 16'h0038,
           16'h003d, 16'h003e, 16'h1fff, 16'h2000, 16'h5fff, 16'h6000, 16'he000, 16'he3ff,
           16'he400, 16'hfe40};
    it = '{16'hfe00, 16'hfe3f, 16'hfe54, 16'hfe60, 16'hfe61, 16'hfe80, 16'hffff};
    fps = 8'h7f;
    foreach (pc[i]) pm_acc(pc[i]);
    fps = 8'h80;
    for (int i = 0; i < 20; i++) pm_acc(16'hfe40 + 16'(i));
    foreach (it[i]) pm_acc(it[i]);
    fps = 8'h00;
    for (int i = 0; i < 24; i++) pm_acc(16'($random(seed)));
    cpu.go(2'd2, 1'b0, 1'b0, 16'h0000, 8'h00);
    `chk("dm_resp", {1'b1, DM_EMPTY_DATA}, dm_resp)
  endtask

  task automatic stop_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    miscompares++;
    stop_test();
  end
  initial begin
    mad_variant_t vars [3];
    vars = '{MAD_VAR_24K, MAD_VAR_16K, MAD_VAR_8K};
    rst_in = 1'b1;
    ce_in = 1'b1;
    reloc = 1'b0;
    fps = 8'h00;
    variant = MAD_VAR_24K;
    repeat (12) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    `chk("rst_valid", 3'b000, {rf_resp.valid, pm_resp.valid, dm_resp.valid})
    `chk("rst_area", MAD_AREA_NONE, pm_area)
    rst_in = 1'b0;
    for (int c = 0; c < 6; c++) begin
      variant = vars[c / 2];
      reloc = c[0];
      rsh.delete();
      psh.delete();
      run_rf();
      run_pm();
    end
    cpu.go(2'd3, 1'b0, 1'b0, 16'h0000, 8'h00);
    stop_test();
  end
endmodule // memory_address_decoder_tb
